// *** tb/lbsl_mem_model.sv ***
`timescale 1ns/1ps
module lbsl_mem_model (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst_n,
    // bus pins seen from outside
    input  wire logic        addr_latch,
    input  wire logic [15:0] muxed_addr_data_o,
    input  wire logic        rd_n_o,
    input  wire logic        rd_n_oe,
    input  wire logic        wr_n_o,
    input  wire logic        wr_n_oe,
    input  wire logic [3:0]  ready_delay,
    output logic [15:0]      muxed_addr_data_i,
    output logic             sync_ready_in,
    output logic             async_ready_in
);
    logic [15:0] addr_r;
    logic [15:0] last_r;
    logic [3:0]  cnt_r;
    logic        rd_w;
    logic        wr_w;
    assign rd_w = rd_n_oe ? rd_n_o : 1'b1;
    assign wr_w = wr_n_oe ? wr_n_o : 1'b1;
    // released lines show the inverse of the last value
    // no memory/io qualifier: the model answers on strobes alone, spaces kept apart
    assign muxed_addr_data_i = !rd_w ? (addr_r ^ 16'h5a5a) : ~last_r;
    assign sync_ready_in = (!rd_w || !wr_w) && (cnt_r >= ready_delay);
    assign async_ready_in = 1'b0;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            addr_r <= 16'h0000;
            last_r <= 16'h0000;
            cnt_r <= 4'h0;
        end else begin
            if (addr_latch)
                addr_r <= muxed_addr_data_o;
            last_r <= muxed_addr_data_i;
            cnt_r <= (!rd_w || !wr_w) ? ((cnt_r == 4'hf) ? cnt_r : cnt_r + 4'h1) : 4'h0;
        end
    end
endmodule

// *** tb/lbsl_top_bench.sv ***
`timescale 1ns/1ps
module lbsl_top_bench;
    import lbsl_pkg::*;
    logic clock = 0, rst_n = 0, cyc_req = 0, cyc_io = 0, cyc_write = 0, cyc_fetch = 0, cyc_upper_n = 0;
    logic cyc_lock = 0, bus_request_in = 0, t, b;
    logic [19:0] cyc_addr = '0;
    logic [15:0] cyc_wdata = '0, cyc_rdata, muxed_addr_data_i, muxed_addr_data_o, rd;
    logic cyc_done, slave_mode, escape_trap, addr_latch, rd_n_o, rd_n_oe, rd_pull_up, wr_n_o, wr_n_oe;
    logic data_buffer_enable_n_o, data_buffer_enable_n_oe, data_direction_o, data_direction_oe;
    logic bus_status_oe, lock_n_o, lock_n_oe, muxed_addr_data_oe, upper_addr_oe, upper_byte_enable_n_o;
    logic upper_byte_enable_n_oe, sync_ready_in, async_ready_in, bus_grant_out;
    logic top_mem_select_n, bottom_mem_select_n;
    logic [2:0] bus_status_o;
    logic [3:0] upper_addr_o, mid_mem_select_n, ready_delay = 0;
    logic [6:0] periph_select_n;
    int num_errors = 0, n_compared = 0, l0, l1, l2, n;
    lbsl_top lbsl_top_i (.*);
    lbsl_mem_model lbsl_mem_model_i (.*);
    always #50 clock = ~clock;
    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic ok, input string m);
        n_compared++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("BAD %0t %s", $time, m);
        end
    endtask
    // one bus cycle; latency in cycles and whether the top and bottom selects went low
    task automatic cyc(input logic [19:0] a, input logic io, wr, input logic [15:0] wd,
                       output logic [15:0] r, output int lat, output logic tp, bt);
        @(negedge clock);
        {cyc_addr, cyc_io, cyc_write, cyc_wdata, cyc_req, tp, bt, lat} = {a, io, wr, wd, 3'b111, 32'd0};
        do begin
            @(posedge clock);
            #1;
            lat++;
            tp &= top_mem_select_n;
            bt &= bottom_mem_select_n;
        end while (cyc_done !== 1'b1 && lat < 40);
        r = cyc_rdata;
        if (lat >= 40) chk(0, "cycle hang");
        @(negedge clock);
        cyc_req = 0;
    endtask
    task automatic wait_grant(input logic v);
        n = 0;
        while (bus_grant_out !== v && n < 10) begin
            @(negedge clock);
            n++;
        end
    endtask
    initial begin
        #(100 * 3000);
        num_errors++;
        stop_test;
    end
    initial begin
        repeat (2) @(negedge clock);
        chk(rd_n_oe === 1 && rd_n_o === 1 && wr_n_o === 1 && data_buffer_enable_n_o === 1, "strobes");
        chk(bus_status_o === ST_PASSIVE && lock_n_o === 1 && muxed_addr_data_oe === 0 && addr_latch === 0, "bus");
        chk(bus_grant_out === 0 && top_mem_select_n === 1 && &periph_select_n === 1, "selects");
        chk(rd_pull_up === 1 && &mid_mem_select_n === 1 && bottom_mem_select_n === 1, "pull-up");
        @(negedge clock);
        rst_n = 1;
        repeat (2) @(negedge clock);
        chk(rd_n_oe === 0 && data_buffer_enable_n_oe === 0, "strobes float");
        cyc(20'h0fffe, 1, 0, 0, rd, l0, t, b);
        chk(rd === RST_RELOCATION, "relocation reset value");
        cyc(20'h0fffe, 1, 1, 16'h60ff, rd, n, t, b);
        chk(data_direction_o === 1, "write direction");
        cyc(20'h0fffe, 1, 0, 0, rd, n, t, b);
        chk(rd === 16'h60ff && slave_mode === 1 && escape_trap === 1, "relocation bits");
        $display("test control block done");
        cyc(20'hffff0, 0, 0, 0, rd, l1, t, b);
        chk(t === 0 && b === 1 && rd === (16'hfff0 ^ 16'h5a5a), "top read");
        chk(upper_addr_o === 4'hf && data_direction_o === 0, "address and direction");
        chk(l1 == l0 + 3, "three waits");
        ready_delay = 4'h8;
        cyc(20'hffff0, 0, 0, 0, rd, l2, t, b);
        chk(l2 > l1, "external ready combined");
        cyc(20'h0fffe, 1, 0, 0, rd, n, t, b);
        chk(n == l0, "control block ignores ready");
        ready_delay = 4'h0;
        $display("test waits done");
        cyc(20'h00010, 0, 0, 0, rd, n, t, b);
        chk(b === 1, "bottom off before access");
        cyc(20'h0ffa2, 1, 1, 16'h0004, rd, n, t, b);
        cyc(20'h00010, 0, 0, 0, rd, n, t, b);
        chk(b === 0 && t === 1, "bottom select");
        cyc(20'h0ffa8, 1, 1, 16'h0044, rd, n, t, b);
        cyc(20'h0ffa6, 1, 1, 16'h0204, rd, n, t, b);
        cyc(20'h0ffa4, 1, 1, 16'h4000, rd, n, t, b);
        cyc(20'h00480, 1, 0, 0, rd, n, t, b);
        chk(periph_select_n === 7'h7d && mid_mem_select_n === 4'hf, "peripheral select");
        cyc(20'h44000, 0, 0, 0, rd, n, t, b);
        chk(mid_mem_select_n === 4'hb && periph_select_n === 7'h7f, "mid select");
        cyc(20'h0ffa6, 1, 1, 16'h0284, rd, n, t, b);
        cyc(20'h00482, 1, 0, 0, rd, n, t, b);
        chk(periph_select_n === 7'h3d, "latched address bits");
        $display("test selects done");
        // one alternate master only, so no outside arbitration
        bus_request_in = 1;
        wait_grant(1);
        chk(bus_grant_out === 1 && rd_n_oe === 0 && wr_n_oe === 0 && bus_status_oe === 0, "hold float");
        chk(muxed_addr_data_oe === 0 && upper_addr_oe === 0 && lock_n_oe === 0, "hold float bus");
        chk(top_mem_select_n === 1 && bottom_mem_select_n === 1, "selects driven in hold");
        bus_request_in = 0;
        wait_grant(0);
        chk(bus_grant_out === 0, "grant drop");
        $display("test hold done");
        stop_test;
    end
endmodule

// *** verilog/lbsl_pkg.sv ***
package lbsl_pkg;
    // control block register offsets (byte offset within the 256-byte block)
    localparam logic [7:0]  OFS_TOP_SEL     = 8'ha0;
    localparam logic [7:0]  OFS_BOTTOM_SEL  = 8'ha2;
    localparam logic [7:0]  OFS_MID_BASE    = 8'ha4;
    localparam logic [7:0]  OFS_MID_PERIPH  = 8'ha6;
    localparam logic [7:0]  OFS_PERIPH_BASE = 8'ha8;
    localparam logic [7:0]  OFS_RELOCATION  = 8'hfe;
    // values after reset
    localparam logic [15:0] RST_TOP_SEL     = 16'hfffb;
    localparam logic [15:0] RST_RELOCATION  = 16'h00ff;
    localparam logic [15:0] RST_OTHER_SEL   = 16'h0000;
    // relocation register fields
    localparam int          RELOC_MEM_BIT   = 12;
    localparam int          RELOC_SLAVE_BIT = 13;
    localparam int          RELOC_ESC_BIT   = 14;
    // select register fields
    localparam int          RDY_IGNORE_BIT  = 2;
    localparam int          ADDR_FIELD_LO   = 6;
    localparam int          MID_SIZE_LO     = 8;
    localparam int          PER_MEM_BIT     = 6;
    localparam int          PER_LATCH_BIT   = 7;
    localparam int          PER_BLOCK_LO    = 7;
    localparam int          NUM_MID         = 4;
    localparam int          NUM_PERIPH      = 7;
    // bus status codes
    localparam logic [2:0]  ST_IO_READ      = 3'h1;
    localparam logic [2:0]  ST_IO_WRITE     = 3'h2;
    localparam logic [2:0]  ST_FETCH        = 3'h4;
    localparam logic [2:0]  ST_MEM_READ     = 3'h5;
    localparam logic [2:0]  ST_MEM_WRITE    = 3'h6;
    localparam logic [2:0]  ST_PASSIVE      = 3'h7;
    // bus cycle states, gray along t4, idle, t1, t2, t3
    typedef enum logic [2:0] {
        S_INIT = 3'b101,
        S_IDLE = 3'b000,
        S_T1   = 3'b001,
        S_T2   = 3'b011,
        S_T3   = 3'b010,
        S_T4   = 3'b100,
        S_HOLD = 3'b110
    } lbsl_state_t;
endpackage

// *** verilog/lbsl_sync.sv ***
`timescale 1ns/1ps
module lbsl_sync (
    // clock and reset
    input  wire logic clock,
    input  wire logic rst_n,
    // level in and out
    input  wire logic din,
    output logic      dout
);
    logic meta_r;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= 1'b0;
            dout   <= 1'b0;
        end else begin
            meta_r <= din;
            dout   <= meta_r;
        end
    end
endmodule

// *** verilog/lbsl_top.sv ***
// Function
// RULE1: pulse address strobe in address phase, then low read or write strobe moves data.
// RULE2: no memory/io qualifier pin; system uses status, disjoint spaces or selects.
// RULE3: several alternate masters need outside arbitration onto the one request/grant pair.
// RULE4: bus request may be asynchronous; it is synchronised inside.
// RULE5: while granted, float enable, strobes, status, lock, address/data, byte enable, direction.
// RULE6: in reset drive enable and both strobes high one clock, then float.
// RULE7: read strobe pin has an internal pull-up.
// RULE8: in reset status and lock high then float; address lines float; strobe low; grant low.
// RULE9: control registers are 16 bits in a 256-byte block in memory or io.
// RULE10: control block cycles look external but ignore pin data and both ready inputs.
// RULE11: block sits on 256-byte boundary; relocation register at FE gives 12 base bits.
// RULE12: relocation register also holds slave mode and escape trap bits.
// RULE13: selects assert for any cycle in range, processor or dma.
// RULE14: top select covers the region holding the start address FFFF0.
// RULE15: bottom select starts at 0; only its upper limit is programmed.
// RULE16: four mid selects share one block of programmable base and size.
// RULE17: seven peripheral selects for seven 128-byte blocks above a programmable base.
// RULE18: sixth and seventh peripheral selects may instead output latched address bits 1, 2.
// RULE19: each select range inserts 0 to 3 programmed wait states.
// RULE20: each range either ignores external ready or combines it with internal waits.
// RULE21: reset drives selects high; top select config resets to FFFB: 1K, three waits.
// RULE22: other selects stay off until accessed; peripherals need both their registers.
// RULE23: grant at end of t4 or idle with bus floated; drop it once request low.
// RULE24: select outputs keep being driven during hold.
// RULE25: with external ready combined, end only after waits expire and ready is high.
`timescale 1ns/1ps
module lbsl_top
    import lbsl_pkg::*;
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst_n,
    // bus cycle requests from processor core and dma
    input  wire logic        cyc_req,
    input  wire logic [19:0] cyc_addr,
    input  wire logic        cyc_io,
    input  wire logic        cyc_write,
    input  wire logic        cyc_fetch,
    input  wire logic        cyc_upper_n,
    input  wire logic        cyc_lock,
    input  wire logic [15:0] cyc_wdata,
    output logic             cyc_done,
    output logic [15:0]      cyc_rdata,
    // configuration seen by the rest of the processor
    output logic             slave_mode,
    output logic             escape_trap,
    // bus control pins
    output logic             addr_latch,
    output logic             rd_n_o,
    output logic             rd_n_oe,
    output logic             rd_pull_up,
    output logic             wr_n_o,
    output logic             wr_n_oe,
    output logic             data_buffer_enable_n_o,
    output logic             data_buffer_enable_n_oe,
    output logic             data_direction_o,
    output logic             data_direction_oe,
    output logic [2:0]       bus_status_o,
    output logic             bus_status_oe,
    output logic             lock_n_o,
    output logic             lock_n_oe,
    // address and data pins
    input  wire logic [15:0] muxed_addr_data_i,
    output logic [15:0]      muxed_addr_data_o,
    output logic             muxed_addr_data_oe,
    output logic [3:0]       upper_addr_o,
    output logic             upper_addr_oe,
    output logic             upper_byte_enable_n_o,
    output logic             upper_byte_enable_n_oe,
    // ready inputs
    input  wire logic        sync_ready_in,
    input  wire logic        async_ready_in,
    // bus exchange
    input  wire logic        bus_request_in,
    output logic             bus_grant_out,
    // chip selects
    output logic             top_mem_select_n,
    output logic             bottom_mem_select_n,
    output logic [3:0]       mid_mem_select_n,
    output logic [6:0]       periph_select_n
);
    typedef struct packed {
        lbsl_state_t st;
        logic        drive;
        logic [1:0]  wait_cnt;
        logic        ign_rdy;
        logic        cb_hit;
        logic [19:0] addr;
        logic        io;
        logic        wr;
        logic        fetch;
        logic        ub_n;
        logic        lock;
        logic [15:0] wdata;
        logic [15:0] rdata;
        logic        done;
        logic [15:0] reloc;
        logic [15:0] top_cfg;
        logic [15:0] bot_cfg;
        logic [15:0] mid_base;
        logic [15:0] mid_periph;
        logic [15:0] per_base;
        logic        bot_ok;
        logic        mb_ok;
        logic        mp_ok;
        logic        pb_ok;
        logic        top_sel_n;
        logic        bot_sel_n;
        logic [3:0]  mid_sel_n;
        logic [6:0]  per_sel_n;
        logic [1:0]  lat_a;
        logic        grant;
    } lbsl_regs_t;

    lbsl_regs_t r_r;
    lbsl_regs_t r_nxt;
    logic       hold_sync;
    logic       async_ready_in_sync;
    logic       ext_rdy;

    lbsl_sync u_hold_sync (                                           // RULE4
        .clock (clock),
        .rst_n (rst_n),
        .din   (bus_request_in),
        .dout  (hold_sync)
    );

    lbsl_sync u_async_ready_in_sync (
        .clock (clock),
        .rst_n (rst_n),
        .din   (async_ready_in),
        .dout  (async_ready_in_sync)
    );

    assign ext_rdy = sync_ready_in | async_ready_in_sync;

    // address decode for a new cycle
    logic        dec_cb;
    logic        dec_top;
    logic        dec_bot;
    logic [3:0]  dec_mid;
    logic [6:0]  dec_per;
    logic [2:0]  dec_rdy;
    logic [9:0]  per_ofs;
    logic [6:0]  mid_mask;
    logic        mid_in;
    logic [1:0]  mid_idx;

    always_comb begin
        dec_cb   = (cyc_io != r_r.reloc[RELOC_MEM_BIT])
                   && (cyc_addr[19:8] == r_r.reloc[11:0]);            // RULE9 RULE11
        dec_top  = !cyc_io && (cyc_addr[19:10] >= r_r.top_cfg[15:ADDR_FIELD_LO]); // RULE14
        dec_bot  = !cyc_io && r_r.bot_ok
                   && (cyc_addr[19:10] <= r_r.bot_cfg[15:ADDR_FIELD_LO]); // RULE15 RULE22
        mid_mask = 7'h7f << r_r.mid_periph[MID_SIZE_LO +: 3];
        mid_in   = !cyc_io && r_r.mb_ok && r_r.mp_ok && !dec_top && !dec_bot
                   && ((cyc_addr[19:13] & mid_mask) == (r_r.mid_base[15:9] & mid_mask)); // RULE16
        mid_idx  = 2'((cyc_addr[19:13] & ~mid_mask) >> (r_r.mid_periph[MID_SIZE_LO +: 3] - 3'h2));
        if (r_r.mid_periph[MID_SIZE_LO +: 3] < 3'h2) begin
            mid_idx = 2'(cyc_addr[19:13] >> 0) & 2'h0;
        end
        dec_mid  = mid_in ? (4'h1 << mid_idx) : 4'h0;
        per_ofs  = 10'(cyc_addr[19:0] - {r_r.per_base[15:ADDR_FIELD_LO], 10'h000});
        dec_per  = 7'h00;
        if ((cyc_io != r_r.mid_periph[PER_MEM_BIT]) && r_r.mp_ok && r_r.pb_ok
            && (cyc_addr[19:10] == r_r.per_base[15:ADDR_FIELD_LO])
            && (per_ofs[9:PER_BLOCK_LO] != 3'h7)) begin               // RULE17 RULE22
            dec_per = 7'h01 << per_ofs[9:PER_BLOCK_LO];
        end
        if (r_r.mid_periph[PER_LATCH_BIT]) begin
            dec_per[6:5] = 2'h0;                                      // RULE18
        end
        if (dec_top) begin
            dec_rdy = r_r.top_cfg[2:0];
        end else if (dec_bot) begin
            dec_rdy = r_r.bot_cfg[2:0];
        end else if (mid_in) begin
            dec_rdy = r_r.mid_periph[2:0];
        end else if (dec_per != 7'h00) begin
            dec_rdy = r_r.per_base[2:0];
        end else begin
            dec_rdy = 3'h0;
        end
    end

    // register file read
    function automatic logic [15:0] reg_read(input lbsl_regs_t s, input logic [7:0] ofs);
        unique case (ofs)
            OFS_TOP_SEL:     reg_read = s.top_cfg;
            OFS_BOTTOM_SEL:  reg_read = s.bot_cfg;
            OFS_MID_BASE:    reg_read = s.mid_base;
            OFS_MID_PERIPH:  reg_read = s.mid_periph;
            OFS_PERIPH_BASE: reg_read = s.per_base;
            OFS_RELOCATION:  reg_read = s.reloc;
            default:         reg_read = 16'h0000;
        endcase
    endfunction

    always_comb begin
        r_nxt      = r_r;
        r_nxt.done = 1'b0;
        unique case (r_r.st)
            S_INIT: begin
                r_nxt.st = S_IDLE;                                    // RULE6
            end
            S_IDLE: begin
                if (hold_sync) begin
                    r_nxt.st    = S_HOLD;                             // RULE23
                    r_nxt.grant = 1'b1;
                    r_nxt.drive = 1'b0;
                end else if (cyc_req) begin
                    r_nxt.st        = S_T1;
                    r_nxt.drive     = 1'b1;
                    r_nxt.addr      = cyc_addr;
                    r_nxt.io        = cyc_io;
                    r_nxt.wr        = cyc_write;
                    r_nxt.fetch     = cyc_fetch;
                    r_nxt.ub_n      = cyc_upper_n;
                    r_nxt.lock      = cyc_lock;
                    r_nxt.wdata     = cyc_wdata;
                    r_nxt.cb_hit    = dec_cb;
                    r_nxt.wait_cnt  = dec_cb ? 2'h0 : dec_rdy[1:0];   // RULE19
                    r_nxt.ign_rdy   = dec_cb | dec_rdy[RDY_IGNORE_BIT]; // RULE10 RULE20
                    r_nxt.top_sel_n = !dec_top;                       // RULE13
                    r_nxt.bot_sel_n = !dec_bot;
                    r_nxt.mid_sel_n = ~dec_mid;
                    r_nxt.per_sel_n = ~dec_per;
                    r_nxt.lat_a     = cyc_addr[2:1];                  // RULE18
                end
            end
            S_T1: begin
                r_nxt.st = S_T2;
            end
            S_T2: begin
                r_nxt.st = S_T3;
            end
            S_T3: begin
                if (r_r.wait_cnt != 2'h0) begin
                    r_nxt.wait_cnt = r_r.wait_cnt - 2'h1;             // RULE19
                end else if (r_r.ign_rdy || ext_rdy) begin            // RULE20 RULE25
                    r_nxt.st    = S_T4;
                    r_nxt.done  = 1'b1;
                    r_nxt.rdata = r_r.cb_hit ? reg_read(r_r, r_r.addr[7:0])
                                             : muxed_addr_data_i;     // RULE10
                    if (r_r.cb_hit) begin
                        unique case (r_r.addr[7:0])
                            OFS_TOP_SEL:     ;
                            OFS_BOTTOM_SEL:  r_nxt.bot_ok = 1'b1;
                            OFS_MID_BASE:    r_nxt.mb_ok  = 1'b1;
                            OFS_MID_PERIPH:  r_nxt.mp_ok  = 1'b1;
                            OFS_PERIPH_BASE: r_nxt.pb_ok  = 1'b1;     // RULE22
                            default:         ;
                        endcase
                    end
                    if (r_r.cb_hit && r_r.wr) begin
                        unique case (r_r.addr[7:0])
                            OFS_TOP_SEL:     r_nxt.top_cfg    = r_r.wdata;
                            OFS_BOTTOM_SEL:  r_nxt.bot_cfg    = r_r.wdata;
                            OFS_MID_BASE:    r_nxt.mid_base   = r_r.wdata;
                            OFS_MID_PERIPH:  r_nxt.mid_periph = r_r.wdata;
                            OFS_PERIPH_BASE: r_nxt.per_base   = r_r.wdata;
                            OFS_RELOCATION:  r_nxt.reloc      = r_r.wdata; // RULE11 RULE12
                            default:         ;
                        endcase
                    end
                end
            end
            S_T4: begin
                r_nxt.top_sel_n = 1'b1;
                r_nxt.bot_sel_n = 1'b1;
                r_nxt.mid_sel_n = 4'hf;
                r_nxt.per_sel_n = 7'h7f;
                r_nxt.lock      = 1'b0;
                if (hold_sync && !r_r.lock) begin
                    r_nxt.st    = S_HOLD;                             // RULE23
                    r_nxt.grant = 1'b1;
                    r_nxt.drive = 1'b0;
                end else begin
                    r_nxt.st = S_IDLE;
                end
            end
            S_HOLD: begin
                if (!hold_sync) begin
                    r_nxt.st    = S_IDLE;                             // RULE23
                    r_nxt.grant = 1'b0;
                end
            end
            default: begin
                r_nxt.st = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            r_r            <= '0;
            r_r.st         <= S_INIT;
            r_r.reloc      <= RST_RELOCATION;
            r_r.top_cfg    <= RST_TOP_SEL;                            // RULE21
            r_r.bot_cfg    <= RST_OTHER_SEL;
            r_r.mid_base   <= RST_OTHER_SEL;
            r_r.mid_periph <= RST_OTHER_SEL;
            r_r.per_base   <= RST_OTHER_SEL;
            r_r.top_sel_n  <= 1'b1;
            r_r.bot_sel_n  <= 1'b1;
            r_r.mid_sel_n  <= 4'hf;
            r_r.per_sel_n  <= 7'h7f;
        end else begin
            r_r <= r_nxt;
        end
    end

    logic in_strobe;
    logic ctl_oe;
    assign in_strobe = (r_r.st == S_T2) || (r_r.st == S_T3);
    assign ctl_oe    = (r_r.st == S_INIT) || r_r.drive;               // RULE5 RULE6 RULE8

    assign cyc_done    = r_r.done;
    assign cyc_rdata   = r_r.rdata;
    assign slave_mode  = r_r.reloc[RELOC_SLAVE_BIT];                  // RULE12
    assign escape_trap = r_r.reloc[RELOC_ESC_BIT];

    assign addr_latch              = (r_r.st == S_T1);                // RULE1 RULE8
    assign rd_n_o                  = !(in_strobe && !r_r.wr);
    assign rd_n_oe                 = ctl_oe;
    assign rd_pull_up              = 1'b1;                            // RULE7
    assign wr_n_o                  = !(in_strobe && r_r.wr);
    assign wr_n_oe                 = ctl_oe;
    assign data_buffer_enable_n_o  = !in_strobe;
    assign data_buffer_enable_n_oe = ctl_oe;
    assign data_direction_o        = r_r.wr;
    assign data_direction_oe       = r_r.drive;
    assign lock_n_o                = !r_r.lock;
    assign lock_n_oe               = ctl_oe;

    always_comb begin
        bus_status_o = ST_PASSIVE;
        if (r_r.st == S_T1 || r_r.st == S_T2 || r_r.st == S_T3) begin
            if (r_r.io) begin
                bus_status_o = r_r.wr ? ST_IO_WRITE : ST_IO_READ;
            end else if (r_r.wr) begin
                bus_status_o = ST_MEM_WRITE;
            end else begin
                bus_status_o = r_r.fetch ? ST_FETCH : ST_MEM_READ;
            end
        end
    end
    assign bus_status_oe = ctl_oe;

    assign muxed_addr_data_o      = (r_r.st == S_T1) ? r_r.addr[15:0] : r_r.wdata;
    assign muxed_addr_data_oe     = r_r.drive && ((r_r.st == S_T1) || (r_r.wr && r_r.st != S_IDLE));
    assign upper_addr_o           = r_r.addr[19:16];
    assign upper_addr_oe          = r_r.drive;
    assign upper_byte_enable_n_o  = r_r.ub_n;
    assign upper_byte_enable_n_oe = r_r.drive;
    assign bus_grant_out          = r_r.grant;

    // selects have no enable: always driven, also in hold
    assign top_mem_select_n    = r_r.top_sel_n;                       // RULE24
    assign bottom_mem_select_n = r_r.bot_sel_n;
    assign mid_mem_select_n    = r_r.mid_sel_n;
    assign periph_select_n     = r_r.mid_periph[PER_LATCH_BIT]
                                 ? {r_r.lat_a, r_r.per_sel_n[4:0]} : r_r.per_sel_n; // RULE18

    sequence s_cb_start;
        (r_r.st == S_T1) && r_r.cb_hit;
    endsequence
    sequence s_cb_end;
        ##3 cyc_done;
    endsequence

    property p_strobe_after_ale;
        @(posedge clock) disable iff (!rst_n) addr_latch |=> (!rd_n_o || !wr_n_o);
    endproperty
    a_strobe_after_ale: assert property (p_strobe_after_ale) else $error("no strobe after address"); // RULE1

    property p_hold_float;
        @(posedge clock) disable iff (!rst_n)
            bus_grant_out |-> !rd_n_oe && !wr_n_oe && !bus_status_oe && !muxed_addr_data_oe && !upper_addr_oe;
    endproperty
    a_hold_float: assert property (p_hold_float) else $error("bus driven while granted"); // RULE5

    property p_init_drive;
        @(posedge clock) disable iff (!rst_n)
            (r_r.st == S_INIT) |-> rd_n_oe && rd_n_o && wr_n_o && data_buffer_enable_n_o
                                   ##1 !rd_n_oe && !wr_n_oe;
    endproperty
    a_init_drive: assert property (p_init_drive) else $error("reset drive not one clock"); // RULE6

    property p_init_quiet;
        @(posedge clock) disable iff (!rst_n)
            (r_r.st == S_INIT) |-> !addr_latch && !bus_grant_out && !muxed_addr_data_oe && bus_status_o == ST_PASSIVE;
    endproperty
    a_init_quiet: assert property (p_init_quiet) else $error("bad pin state after reset"); // RULE8

    property p_cb_no_wait;
        @(posedge clock) disable iff (!rst_n) s_cb_start |-> s_cb_end;
    endproperty
    a_cb_no_wait: assert property (p_cb_no_wait) else $error("control block cycle waited"); // RULE10

    property p_wait_count;
        @(posedge clock) disable iff (!rst_n)
            (r_r.st == S_T3 && r_r.wait_cnt != 2'h0) |=> (r_r.st == S_T3 && !cyc_done);
    endproperty
    a_wait_count: assert property (p_wait_count) else $error("wait state skipped"); // RULE19

    property p_ext_ready;
        @(posedge clock) disable iff (!rst_n)
            (r_r.st == S_T3 && r_r.wait_cnt == 2'h0 && !r_r.ign_rdy && !ext_rdy) |=> (r_r.st == S_T3);
    endproperty
    a_ext_ready: assert property (p_ext_ready) else $error("cycle ended without ready"); // RULE25

    property p_grant_point;
        @(posedge clock) disable iff (!rst_n)
            $rose(bus_grant_out) |-> ($past(r_r.st) == S_IDLE || $past(r_r.st) == S_T4);
    endproperty
    a_grant_point: assert property (p_grant_point) else $error("grant outside idle or t4"); // RULE23

    property p_periph_off;
        @(posedge clock) disable iff (!rst_n) !(r_r.mp_ok && r_r.pb_ok) |-> (&periph_select_n[4:0]);
    endproperty
    a_periph_off: assert property (p_periph_off) else $error("peripheral select before setup"); // RULE22

    property p_latched_addr;
        @(posedge clock) disable iff (!rst_n)
            r_r.mid_periph[PER_LATCH_BIT] |-> periph_select_n[6:5] == r_r.lat_a;
    endproperty
    a_latched_addr: assert property (p_latched_addr) else $error("latched address bits wrong"); // RULE18
endmodule
